// ### rtl/crtc_pkg.sv
// constants for the crt timing and cursor register block
package crtc_pkg;
   // -----------------------------------------------------------------
   // io ports
   // -----------------------------------------------------------------
   localparam logic [15:0] CRTC_MONO_INDEX_PORT  = 16'h03b4;
   localparam logic [15:0] CRTC_MONO_DATA_PORT   = 16'h03b5;
   localparam logic [15:0] CRTC_COLOR_INDEX_PORT = 16'h03d4;
   localparam logic [15:0] CRTC_COLOR_DATA_PORT  = 16'h03d5;
   // -----------------------------------------------------------------
   // register indexes
   // -----------------------------------------------------------------
   localparam logic [4:0] IDX_HORIZONTAL_TOTAL       = 5'h00;
   localparam logic [4:0] IDX_HORIZONTAL_DISPLAY_END = 5'h01;
   localparam logic [4:0] IDX_HORIZONTAL_BLANK_START = 5'h02;
   localparam logic [4:0] IDX_HORIZONTAL_BLANK_END   = 5'h03;
   localparam logic [4:0] IDX_HORIZONTAL_RETR_START  = 5'h04;
   localparam logic [4:0] IDX_HORIZONTAL_RETR_END    = 5'h05;
   localparam logic [4:0] IDX_VERTICAL_TOTAL         = 5'h06;
   localparam logic [4:0] IDX_VERTICAL_OVERFLOW      = 5'h07;
   localparam logic [4:0] IDX_ROW_SCAN_PRESET        = 5'h08;
   localparam logic [4:0] IDX_MAX_SCAN_LINE          = 5'h09;
   localparam logic [4:0] IDX_CURSOR_START_ROW       = 5'h0a;
   localparam logic [4:0] IDX_CURSOR_END_ROW         = 5'h0b;
   localparam logic [4:0] IDX_SCREEN_START_HIGH      = 5'h0c;
   localparam logic [4:0] IDX_SCREEN_START_LOW       = 5'h0d;
   localparam logic [4:0] IDX_CURSOR_POSITION_HIGH   = 5'h0e;
   localparam logic [4:0] IDX_CURSOR_POSITION_LOW    = 5'h0f;
   localparam logic [4:0] IDX_VERTICAL_RETR_START    = 5'h10;
   localparam int         CRTC_NUM_REGS              = 17;
   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int SKEW_LSB         = 5;   // skew / delay / pan fields 6:5
   localparam int HBE_HIGH_BIT     = 7;   // sixth blank end bit in 05h
   localparam int OVF_VT8          = 0;
   localparam int OVF_VDE8         = 1;
   localparam int OVF_VRS8         = 2;
   localparam int OVF_VBS8         = 3;
   localparam int OVF_LC8          = 4;
   localparam int OVF_VT9          = 5;
   localparam int OVF_VDE9         = 6;
   localparam int OVF_VRS9         = 7;
   localparam int MSL_DOUBLE       = 7;
   localparam int MSL_LC9          = 6;
   localparam int MSL_VBS9         = 5;
   localparam int CUR_OFF_BIT      = 5;
   localparam int LOCK_VERT_BIT    = 0;
   localparam int LOCK_VDE_BIT     = 1;
   localparam int LOCK_EXT_LSB     = 3;   // address extension bits 4:3
   localparam int LOCK_HORIZ_BIT   = 5;
   // -----------------------------------------------------------------
   // offsets, reset values and write masks
   // -----------------------------------------------------------------
   localparam logic [9:0] HTOTAL_EXTRA   = 10'h004;  // wrap at field + 5 - 1
   localparam logic [9:0] VTOTAL_EXTRA   = 10'h001;  // wrap at field + 2 - 1
   localparam logic [7:0] CRTC_REG_RESET = 8'h00;
   localparam logic [7:0] OVF_PROT_MASK  = 8'hef;    // all but line compare bit
endpackage : crtc_pkg

// ### rtl/crtc_row_scan.sv
// row scan counter with preset, maximum clear and line doubling
`timescale 1ns/10ps
module crtc_row_scan
   import crtc_pkg::*;
#(
   parameter int ROW_W = 5
) (
   // clock and reset
   input  wire logic             core_clk_in,
   input  wire logic             reset_in,
   // events
   input  wire logic             frame_start_in,
   input  wire logic             line_end_in,
   // settings
   input  wire logic             double_in,
   input  wire logic [ROW_W-1:0] preset_in,
   input  wire logic [ROW_W-1:0] max_in,
   // state
   output logic [ROW_W-1:0]      row_out
);
   if (ROW_W != 5) begin : g_bad_width
      $error("crtc_row_scan row width must be 5");
   end

   logic [ROW_W-1:0] row_ff;
   logic             half_ff;

   // line doubling halves the clock of the row counter
   always_ff @(posedge core_clk_in) begin
      if (reset_in || frame_start_in) begin
         half_ff <= 1'b0;
      end else if (line_end_in) begin
         half_ff <= ~half_ff;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         row_ff <= '0;
      end else if (frame_start_in) begin
         row_ff <= preset_in;
      end else if (line_end_in && (!double_in || half_ff)) begin
         if (row_ff == max_in) begin
            row_ff <= '0;
         end else begin
            row_ff <= row_ff + 1'b1;
         end
      end
   end

   assign row_out = row_ff;
endmodule : crtc_row_scan

// ### rtl/crtc_skew.sv
// selectable zero to three clock delay line
`timescale 1ns/10ps
module crtc_skew
   import crtc_pkg::*;
#(
   parameter int MAX_DELAY = 3
) (
   // clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       reset_in,
   // data
   input  wire logic [1:0] sel_in,
   input  wire logic       d_in,
   output logic            q_out
);
   if (MAX_DELAY < 3) begin : g_bad_delay
      $error("crtc_skew needs at least three stages");
   end

   logic [MAX_DELAY:1] pipe_ff;

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         pipe_ff <= '0;
      end else begin
         pipe_ff <= {pipe_ff[MAX_DELAY-1:1], d_in};
      end
   end

   // sel 0 passes straight through; the caller registers the result
   always_comb begin
      case (sel_in)
         2'h0:    q_out = d_in;
         2'h1:    q_out = pipe_ff[1];
         2'h2:    q_out = pipe_ff[2];
         2'h3:    q_out = pipe_ff[3];
         default: q_out = d_in;
      endcase
   end
endmodule : crtc_skew

// ### rtl/crtc_timing.sv
// crt controller timing and cursor registers, counters and sync outputs
`timescale 1ns/10ps
module crtc_timing
   import crtc_pkg::*;
#(
   parameter int H_W = 10,
   parameter int V_W = 10
) (
   // clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        reset_in,
   // host io port
   input  wire logic [15:0] io_addr_in,
   input  wire logic        io_wr_in,
   input  wire logic        io_rd_in,
   input  wire logic [7:0]  io_wdata_in,
   output logic [7:0]       io_rdata_out,
   output logic             io_rvalid_out,
   // controls owned elsewhere in the chip
   input  wire logic        color_select_in,
   input  wire logic [7:0]  extension_lock_register_in,
   input  wire logic        write_protect_in,
   input  wire logic        compat_mode_in,
   input  wire logic        multi_shift_in,
   input  wire logic [17:0] refresh_addr_in,
   // raster timing
   output logic [H_W-1:0]   h_count_out,
   output logic [V_W-1:0]   v_count_out,
   output logic [4:0]       row_scan_out,
   output logic             hblank_out,
   output logic             hretrace_out,
   output logic             display_enable_out,
   output logic             cursor_out,
   output logic [1:0]       pan_out,
   // addresses and vertical compare values
   output logic [17:0]      start_addr_out,
   output logic [9:0]       vretrace_start_out,
   output logic [1:0]       vdisp_end_high_out,
   output logic [1:0]       line_compare_high_out,
   output logic [1:0]       vblank_start_high_out
);
   // total and display end are 10-bit compares, so wider counters cannot be served
   if (H_W < 9 || H_W > 10 || V_W != 10) begin : g_bad_width
      $error("crtc_timing counter widths unsupported");
   end

   // ----------------------------------------------------------------
   // io port decode
   // ----------------------------------------------------------------
   logic [15:0] index_port;
   logic [15:0] data_port;
   logic        sel_index;
   logic        sel_data;

   assign index_port = color_select_in ? CRTC_COLOR_INDEX_PORT : CRTC_MONO_INDEX_PORT;
   assign data_port  = color_select_in ? CRTC_COLOR_DATA_PORT : CRTC_MONO_DATA_PORT;
   assign sel_index  = (io_addr_in == index_port);
   assign sel_data   = (io_addr_in == data_port);

   // ----------------------------------------------------------------
   // index pointer and register file
   // ----------------------------------------------------------------
   logic [4:0] index_ff;
   logic [7:0] regs_ff [CRTC_NUM_REGS];
   logic       lock_horiz;
   logic       lock_vert;
   logic       lock_vde;
   logic       in_range;
   logic [7:0] wr_mask;

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         index_ff <= 5'h00;
      end else if (io_wr_in && sel_index) begin
         index_ff <= io_wdata_in[4:0];
      end
   end

   assign lock_horiz = extension_lock_register_in[LOCK_HORIZ_BIT] | write_protect_in;
   assign lock_vert  = extension_lock_register_in[LOCK_VERT_BIT] | write_protect_in;
   assign lock_vde   = ~extension_lock_register_in[LOCK_VDE_BIT] & write_protect_in;
   assign in_range   = (index_ff <= IDX_VERTICAL_RETR_START);

   // per-bit write mask so the overflow register can be partly locked
   always_comb begin
      wr_mask = 8'hff;
      case (index_ff)
         IDX_HORIZONTAL_TOTAL, IDX_HORIZONTAL_DISPLAY_END, IDX_HORIZONTAL_BLANK_START,
         IDX_HORIZONTAL_BLANK_END, IDX_HORIZONTAL_RETR_START, IDX_HORIZONTAL_RETR_END: begin
            wr_mask = lock_horiz ? 8'h00 : 8'hff;
         end
         IDX_VERTICAL_TOTAL: begin
            wr_mask = lock_vert ? 8'h00 : 8'hff;
         end
         IDX_VERTICAL_OVERFLOW: begin
            wr_mask = 8'hff;
            if (lock_vert) begin
               wr_mask = wr_mask & ~(OVF_PROT_MASK & 8'hbd);
            end
            if (lock_vde) begin
               wr_mask = wr_mask & ~8'h42;
            end
         end
         IDX_CURSOR_START_ROW, IDX_VERTICAL_RETR_START: begin
            wr_mask = extension_lock_register_in[LOCK_VERT_BIT] ? 8'h00 : 8'hff;
         end
         default: begin
            wr_mask = 8'hff;
         end
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         for (int i = 0; i < CRTC_NUM_REGS; i++) begin
            regs_ff[i] <= CRTC_REG_RESET;
         end
      end else if (io_wr_in && sel_data && in_range) begin
         regs_ff[index_ff] <= (regs_ff[index_ff] & ~wr_mask) | (io_wdata_in & wr_mask);
      end
   end

   // reads answer one clock after the strobe
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         io_rdata_out  <= 8'h00;
         io_rvalid_out <= 1'b0;
      end else begin
         io_rvalid_out <= io_rd_in && (sel_index || sel_data);
         if (io_rd_in && sel_index) begin
            io_rdata_out <= {3'h0, index_ff};
         end else if (io_rd_in && sel_data) begin
            io_rdata_out <= in_range ? regs_ff[index_ff] : 8'h00;
         end
      end
   end

   // ----------------------------------------------------------------
   // field extraction
   // ----------------------------------------------------------------
   logic [7:0] r_ovf;
   logic [7:0] r_msl;
   logic [9:0] htotal_last;
   logic [9:0] hde_last;
   logic [5:0] hblank_end;
   logic [4:0] hretr_end;
   logic [1:0] de_skew;
   logic [1:0] hr_delay;
   logic [1:0] cur_skew;
   logic [9:0] vtotal;
   logic [9:0] vtotal_last;
   logic [4:0] cur_first;
   logic [4:0] cur_last;
   logic [7:0] start_high;

   assign r_ovf       = regs_ff[IDX_VERTICAL_OVERFLOW];
   assign r_msl       = regs_ff[IDX_MAX_SCAN_LINE];
   assign htotal_last = {2'h0, regs_ff[IDX_HORIZONTAL_TOTAL]} + HTOTAL_EXTRA;
   assign hde_last    = {2'h0, regs_ff[IDX_HORIZONTAL_DISPLAY_END]};
   assign hblank_end  = {regs_ff[IDX_HORIZONTAL_RETR_END][HBE_HIGH_BIT],
                         regs_ff[IDX_HORIZONTAL_BLANK_END][4:0]};
   assign hretr_end   = regs_ff[IDX_HORIZONTAL_RETR_END][4:0];
   assign de_skew     = regs_ff[IDX_HORIZONTAL_BLANK_END][SKEW_LSB+:2];
   assign hr_delay    = regs_ff[IDX_HORIZONTAL_RETR_END][SKEW_LSB+:2];
   assign cur_skew    = regs_ff[IDX_CURSOR_END_ROW][SKEW_LSB+:2];
   assign vtotal      = {r_ovf[OVF_VT9], r_ovf[OVF_VT8], regs_ff[IDX_VERTICAL_TOTAL]};
   assign vtotal_last = vtotal + VTOTAL_EXTRA;
   assign cur_first   = regs_ff[IDX_CURSOR_START_ROW][4:0];
   assign cur_last    = regs_ff[IDX_CURSOR_END_ROW][4:0];
   // compat mode forces start high bits 7:6 (address bits 15:14) low in the address used
   assign start_high  = compat_mode_in ? {2'h0, regs_ff[IDX_SCREEN_START_HIGH][5:0]}
                                       : regs_ff[IDX_SCREEN_START_HIGH];

   // ----------------------------------------------------------------
   // horizontal and vertical counters
   // ----------------------------------------------------------------
   logic [H_W-1:0] h_ff;
   logic [V_W-1:0] v_ff;
   logic           line_end;
   logic           frame_end;

   assign line_end  = (h_ff == htotal_last[H_W-1:0]);
   assign frame_end = line_end && (v_ff == vtotal_last);

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         h_ff <= '0;
      end else if (line_end) begin
         h_ff <= '0;
      end else begin
         h_ff <= h_ff + 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         v_ff <= '0;
      end else if (frame_end) begin
         v_ff <= '0;
      end else if (line_end) begin
         v_ff <= v_ff + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // blanking and retrace state
   // ----------------------------------------------------------------
   logic hblank_ff;
   logic hretr_ff;
   logic hretr_fall;
   logic hretr_q_ff;

   // start match wins when start and end hit in the same clock
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         hblank_ff <= 1'b0;
      end else if (h_ff == {{(H_W-8){1'b0}}, regs_ff[IDX_HORIZONTAL_BLANK_START]}) begin
         hblank_ff <= 1'b1;
      end else if (h_ff[5:0] == hblank_end) begin
         hblank_ff <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         hretr_ff <= 1'b0;
      end else if (h_ff == {{(H_W-8){1'b0}}, regs_ff[IDX_HORIZONTAL_RETR_START]}) begin
         hretr_ff <= 1'b1;
      end else if (h_ff[4:0] == hretr_end) begin
         hretr_ff <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         hretr_q_ff <= 1'b0;
      end else begin
         hretr_q_ff <= hretr_ff;
      end
   end

   // row scan steps at the close of each horizontal retrace, or of every second one when line doubling is on
   assign hretr_fall = hretr_q_ff & ~hretr_ff;

   // ----------------------------------------------------------------
   // row scan
   // ----------------------------------------------------------------
   logic [4:0] row;

   crtc_row_scan #(
      .ROW_W (5)
   ) u_row_scan (
      .core_clk_in    (core_clk_in),
      .reset_in       (reset_in),
      .frame_start_in (frame_end),
      .line_end_in    (hretr_fall),
      .double_in      (r_msl[MSL_DOUBLE]),
      .preset_in      (regs_ff[IDX_ROW_SCAN_PRESET][4:0]),
      .max_in         (r_msl[4:0]),
      .row_out        (row)
   );

   // ----------------------------------------------------------------
   // display enable, cursor and skew lines
   // ----------------------------------------------------------------
   logic [17:0] cursor_addr;
   logic        de_raw;
   logic        cur_raw;
   logic        de_skewed;
   logic        hr_skewed;
   logic        cur_skewed;

   assign de_raw      = ({{(10-H_W+10){1'b0}}, h_ff} <= {10'h000, hde_last});
   assign cursor_addr = {extension_lock_register_in[LOCK_EXT_LSB+:2],
                         regs_ff[IDX_CURSOR_POSITION_HIGH],
                         regs_ff[IDX_CURSOR_POSITION_LOW]};
   assign cur_raw     = !regs_ff[IDX_CURSOR_START_ROW][CUR_OFF_BIT]
                        && (cur_first <= cur_last)
                        && (row >= cur_first) && (row <= cur_last)
                        && (refresh_addr_in == cursor_addr)
                        && de_raw;

   crtc_skew #(
      .MAX_DELAY (3)
   ) u_de_skew (
      .core_clk_in (core_clk_in),
      .reset_in    (reset_in),
      .sel_in      (de_skew),
      .d_in        (de_raw),
      .q_out       (de_skewed)
   );

   crtc_skew #(
      .MAX_DELAY (3)
   ) u_hr_delay (
      .core_clk_in (core_clk_in),
      .reset_in    (reset_in),
      .sel_in      (hr_delay),
      .d_in        (hretr_ff),
      .q_out       (hr_skewed)
   );

   crtc_skew #(
      .MAX_DELAY (3)
   ) u_cur_skew (
      .core_clk_in (core_clk_in),
      .reset_in    (reset_in),
      .sel_in      (cur_skew),
      .d_in        (cur_raw),
      .q_out       (cur_skewed)
   );

   // ----------------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         h_count_out        <= '0;
         v_count_out        <= '0;
         row_scan_out       <= 5'h00;
         hblank_out         <= 1'b0;
         hretrace_out       <= 1'b0;
         display_enable_out <= 1'b0;
         cursor_out         <= 1'b0;
         pan_out            <= 2'h0;
      end else begin
         h_count_out        <= h_ff;
         v_count_out        <= v_ff;
         row_scan_out       <= row;
         hblank_out         <= hblank_ff;
         hretrace_out       <= hr_skewed;
         display_enable_out <= de_skewed;
         cursor_out         <= cur_skewed;
         // panning only has meaning in multiple-shift modes
         pan_out            <= multi_shift_in ? regs_ff[IDX_ROW_SCAN_PRESET][SKEW_LSB+:2] : 2'h0;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         start_addr_out        <= 18'h00000;
         vretrace_start_out    <= 10'h000;
         vdisp_end_high_out    <= 2'h0;
         line_compare_high_out <= 2'h0;
         vblank_start_high_out <= 2'h0;
      end else begin
         start_addr_out        <= {extension_lock_register_in[LOCK_EXT_LSB+:2], start_high,
                                   regs_ff[IDX_SCREEN_START_LOW]};
         vretrace_start_out    <= {r_ovf[OVF_VRS9], r_ovf[OVF_VRS8],
                                   regs_ff[IDX_VERTICAL_RETR_START]};
         vdisp_end_high_out    <= {r_ovf[OVF_VDE9], r_ovf[OVF_VDE8]};
         line_compare_high_out <= {r_msl[MSL_LC9], r_ovf[OVF_LC8]};
         vblank_start_high_out <= {r_msl[MSL_VBS9], r_ovf[OVF_VBS8]};
      end
   end
endmodule : crtc_timing

// ### tb/crtc_monitor.sv
// raster monitor model: counts retrace pulses and blanked clocks
`timescale 1ns/10ps
module crtc_monitor (
   // sync and blank from the controller
   input  wire logic core_clk_in,
   input  wire logic clear_in,
   input  wire logic hretrace_in,
   input  wire logic hblank_in,
   // what the screen saw
   output int        lines_out,
   output int        blank_clks_out
);
   logic prev_ff;
   always_ff @(posedge core_clk_in) begin
      prev_ff <= hretrace_in;
      // the monitor counts retrace edges and blanked clocks, so delays change nothing but phase
      lines_out      <= clear_in ? 0 : lines_out + int'(hretrace_in && !prev_ff);
      blank_clks_out <= clear_in ? 0 : blank_clks_out + int'(hblank_in);
   end
endmodule : crtc_monitor

// ### tb/crtc_timing_asserts.sv
// concurrent checks on the crt timing block ports
`timescale 1ns/10ps
module crtc_timing_chk
   import crtc_pkg::*;
(
   // clock, reset and host port
   input wire logic        core_clk_in,
   input wire logic        reset_in,
   input wire logic [15:0] io_addr_in,
   input wire logic        io_rd_in,
   input wire logic [7:0]  io_rdata_out,
   input wire logic        io_rvalid_out,
   // controls and timing
   input wire logic        color_select_in,
   input wire logic        compat_mode_in,
   input wire logic        multi_shift_in,
   input wire logic [9:0]  h_count_out,
   input wire logic [9:0]  v_count_out,
   input wire logic [1:0]  pan_out,
   input wire logic [17:0] start_addr_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   logic [15:0] own_port;
   logic [15:0] alt_port;
   assign own_port = color_select_in ? CRTC_COLOR_DATA_PORT : CRTC_MONO_DATA_PORT;
   assign alt_port = color_select_in ? CRTC_MONO_DATA_PORT : CRTC_COLOR_DATA_PORT;
   property p_rd_answer; io_rd_in && io_addr_in == own_port |=> io_rvalid_out; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   property p_alt_port; io_rd_in && io_addr_in == alt_port |=> !io_rvalid_out; endproperty
   a_alt_port: assert property (p_alt_port) else $error("other range answered");
   property p_rd_cause; io_rvalid_out |-> $past(io_rd_in); endproperty
   a_rd_cause: assert property (p_rd_cause) else $error("answer without read");
   property p_rd_hold; !io_rvalid_out |-> $stable(io_rdata_out); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_h_step; 1'b1 |=> h_count_out == $past(h_count_out) + 10'h001 || h_count_out == 10'h000; endproperty
   a_h_step: assert property (p_h_step) else $error("horizontal count skipped");
   property p_v_step; $changed(v_count_out) |-> h_count_out == 10'h000; endproperty
   a_v_step: assert property (p_v_step) else $error("line count moved mid line");
   property p_pan_off; !multi_shift_in && !$past(multi_shift_in) |-> pan_out == 2'h0; endproperty
   a_pan_off: assert property (p_pan_off) else $error("pan outside shift mode");
   property p_compat; compat_mode_in && $past(compat_mode_in) |-> start_addr_out[15:14] == 2'h0; endproperty
   a_compat: assert property (p_compat) else $error("compat high bits set");
endmodule : crtc_timing_chk
bind crtc_timing crtc_timing_chk u_chk (.core_clk_in, .reset_in, .io_addr_in, .io_rd_in, .io_rdata_out,
   .io_rvalid_out, .color_select_in, .compat_mode_in, .multi_shift_in, .h_count_out, .v_count_out,
   .pan_out, .start_addr_out);

// ### tb/tb.sv
// self-checking bench for the crt timing block
`timescale 1ns/10ps
module tb
   import crtc_pkg::*;
;
   logic core_clk_in = 1'b0, reset_in = 1'b1, io_wr_in = 1'b0, io_rd_in = 1'b0, color_select_in = 1'b1;
   logic write_protect_in = 1'b0, compat_mode_in = 1'b0, multi_shift_in = 1'b0, mon_clear = 1'b1;
   logic [15:0] io_addr_in = 16'h0000;
   logic [7:0]  io_wdata_in = 8'h00, extension_lock_register_in = 8'h00, io_rdata_out;
   logic        io_rvalid_out, hblank_out, hretrace_out, display_enable_out, cursor_out;
   logic [9:0]  h_count_out, v_count_out, vretrace_start_out;
   logic [1:0]  pan_out, vdisp_end_high_out, line_compare_high_out, vblank_start_high_out;
   logic [17:0] start_addr_out, refresh_addr_in = 18'h00000;
   logic [4:0]  row_scan_out;
   logic [7:0]  bl_map, de_map, hr_map, cur_map;
   int          n_fail = 0, samples_checked = 0, lines, blanks, cnt;
   always #25 core_clk_in = ~core_clk_in;
   crtc_timing u_dut (.core_clk_in, .reset_in, .io_addr_in, .io_wr_in, .io_rd_in, .io_wdata_in, .io_rdata_out,
      .io_rvalid_out, .color_select_in, .extension_lock_register_in, .write_protect_in, .compat_mode_in,
      .multi_shift_in, .refresh_addr_in, .h_count_out, .v_count_out, .row_scan_out, .hblank_out,
      .hretrace_out, .display_enable_out, .cursor_out, .pan_out, .start_addr_out, .vretrace_start_out,
      .vdisp_end_high_out, .line_compare_high_out, .vblank_start_high_out);
   crtc_monitor u_mon (.core_clk_in, .clear_in(mon_clear), .hretrace_in(hretrace_out), .hblank_in(hblank_out),
      .lines_out(lines), .blank_clks_out(blanks));
   task automatic check(string what, logic [17:0] seen, logic [17:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tick(int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask : tick
   // one 8-clock line mapped by horizontal position; pipelines settle first
   task automatic scan_line();
      tick(4);
      for (int i = 0; i < 8; i++) begin
         tick(1);
         bl_map[h_count_out[2:0]]  = hblank_out;
         de_map[h_count_out[2:0]]  = display_enable_out;
         hr_map[h_count_out[2:0]]  = hretrace_out;
         cur_map[h_count_out[2:0]] = cursor_out;
      end
   endtask : scan_line
   // sum of row scan over one whole 24-clock frame, phase free
   task automatic row_sum();
      tick(24);
      cnt = 0;
      for (int i = 0; i < 24; i++) begin
         tick(1);
         cnt += int'(row_scan_out);
      end
   endtask : row_sum
   function automatic logic [15:0] port(logic dat);
      return (color_select_in ? CRTC_COLOR_INDEX_PORT : CRTC_MONO_INDEX_PORT) + {15'h0000, dat};
   endfunction : port
   task automatic wr(logic [7:0] idx, logic [7:0] d);
      tick(1); io_wr_in = 1'b1; io_addr_in = port(1'b0); io_wdata_in = idx;
      tick(1); io_addr_in = port(1'b1); io_wdata_in = d;
      tick(1); io_wr_in = 1'b0;
   endtask : wr
   task automatic rd(logic [7:0] idx, logic [7:0] exp);
      tick(1); io_wr_in = 1'b1; io_addr_in = port(1'b0); io_wdata_in = idx;
      tick(1); io_wr_in = 1'b0; io_rd_in = 1'b1; io_addr_in = port(1'b1);
      tick(1); io_rd_in = 1'b0;
      check("rvalid", io_rvalid_out, 1'b1);
      check("rdata", io_rdata_out, exp);
   endtask : rd
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   initial begin
      tick(3); reset_in = 1'b0;
      cnt = 0;
      for (int i = 0; i < 50; i++) begin tick(1); cnt += int'(h_count_out == 10'h000); end
      check("line rate", cnt, 10);
      wr(8'h0c, 8'ha5); rd(8'h0c, 8'ha5);
      color_select_in = 1'b0;
      tick(1); io_rd_in = 1'b1; io_addr_in = CRTC_COLOR_DATA_PORT;
      tick(1); io_rd_in = 1'b0;
      check("other range", io_rvalid_out, 1'b0);
      rd(8'h0c, 8'ha5); $display("test ports done");
      wr(8'h00, 8'h03); extension_lock_register_in = 8'h20; wr(8'h00, 8'h07); rd(8'h00, 8'h03);
      extension_lock_register_in = 8'h00; write_protect_in = 1'b1;
      wr(8'h07, 8'hff); rd(8'h07, 8'h10);
      extension_lock_register_in = 8'h02; wr(8'h07, 8'hff); rd(8'h07, 8'h52);
      check("vde high", vdisp_end_high_out, 2'h3);
      write_protect_in = 1'b0; extension_lock_register_in = 8'h00; $display("test locks done");
      wr(8'h02, 8'h02); wr(8'h03, 8'h66); wr(8'h04, 8'h04); wr(8'h05, 8'h67); wr(8'h01, 8'h01);
      tick(1); mon_clear = 1'b0; tick(80);
      check("blank clocks", blanks, 40);
      check("retrace pulses", lines, 10);
      scan_line();
      check("blank phase", bl_map, 8'h78);
      check("de phase", de_map, 8'h18);
      check("retrace phase", hr_map, 8'h07);
      wr(8'h06, 8'h01); cnt = 0;
      for (int i = 0; i < 48; i++) begin tick(1); if (v_count_out > cnt) cnt = v_count_out; end
      check("last line", cnt, 2); $display("test timing done");
      scan_line();
      check("cursor", cur_map, 8'h03);
      wr(8'h0b, 8'h20); scan_line();
      check("cursor skew", cur_map, 8'h06);
      refresh_addr_in = 18'h00001; scan_line();
      check("cursor miss", cur_map, 8'h00);
      wr(8'h0f, 8'h01); scan_line();
      check("cursor hit", cur_map, 8'h06);
      wr(8'h0a, 8'h20); scan_line();
      check("cursor off", cur_map, 8'h00);
      $display("test cursor done");
      wr(8'h08, 8'h04); wr(8'h09, 8'h06); row_sum();
      check("row sum", cnt, 92);
      wr(8'h09, 8'he6); wr(8'h10, 8'h5a); row_sum();
      check("row double", cnt, 111);
      check("lc high", line_compare_high_out, 2'h3);
      check("vbs high", vblank_start_high_out, 2'h2);
      check("vrs", vretrace_start_out, 10'h05a);
      $display("test rows done");
      extension_lock_register_in = 8'h10; wr(8'h0c, 8'hff); wr(8'h0d, 8'h34); tick(2);
      check("start addr", start_addr_out, 18'h2ff34);
      compat_mode_in = 1'b1; tick(2);
      check("compat addr", start_addr_out, 18'h23f34);
      wr(8'h08, 8'h60); multi_shift_in = 1'b1; tick(2);
      check("pan", pan_out, 2'h3);
      multi_shift_in = 1'b0; tick(2);
      check("no pan", pan_out, 2'h0); $display("test addr done");
      end_of_test();
   end
endmodule : tb
